// ---- src/pioc_map.svh ----
// register offsets, field masks and reset values of the port configuration block
`ifndef PIOC_MAP_SVH
`define PIOC_MAP_SVH
`define PIOC_OFS_PA_ANSEL   4'h0
`define PIOC_OFS_PA_DIR     4'h1
`define PIOC_OFS_PA_LAT     4'h2
`define PIOC_OFS_PA_ODC     4'h3
`define PIOC_OFS_PA_PORT    4'h4
`define PIOC_OFS_PB_ANSEL   4'h8
`define PIOC_OFS_PB_DIR     4'h9
`define PIOC_OFS_PB_LAT     4'ha
`define PIOC_OFS_PB_ODC     4'hb
`define PIOC_OFS_PB_PORT    4'hc
`define PIOC_PA_ANS_MASK    16'h06c0
`define PIOC_PA_ANS_MASK_SM 16'h0040
`define PIOC_PB_ANS_MASK    16'hffff
`define PIOC_RST_ANS        16'hffff
`define PIOC_RST_DIR        16'hffff
`define PIOC_RST_ZERO       16'h0000
`define PIOC_RD_ZERO        32'h0000_0000
`define PIOC_RST_WAIT       1'b1
`endif

// ---- src/pioc_pkg.sv ----
// types shared by the port configuration block
package pioc_pkg;
  typedef logic [15:0] pioc_word_t;
  // configuration of one 16-bit port
  typedef struct packed {
    pioc_word_t ansel;
    pioc_word_t dir;
    pioc_word_t lat;
    pioc_word_t odc;
  } pioc_port_cfg_t;
  // avalon request bundle
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pioc_av_req_t;
  typedef enum logic [0:0] {PIOC_IDLE, PIOC_DONE} pioc_bus_st_t;
endpackage

// ---- src/pioc_port_cfg.sv ----
// two-port pin configuration block with analog select, open drain and port read
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "pioc_map.svh"

// register words, one 16-bit register in the low half of each 32-bit word:
//   word 0  port A analog select     word 8  port B analog select
//   word 1  port A direction         word 9  port B direction
//   word 2  port A output latch      word 10 port B output latch
//   word 3  port A open drain        word 11 port B open drain
//   word 4  port A pin read          word 12 port B pin read
// direction one means input and resets to one, so every pin starts released;
// latch and open drain reset to zero. writes to the pin-read words and to
// unmapped words are dropped, reads of unmapped words give zero.
// each access costs two edges: the request is taken on the first, waitrequest
// is low for the second. pins reach the read path two edges after they move.

// Notes on behaviour
// - each pin has its own open-drain bit turning push-pull into open-drain.
// - one analog-select bit per analog pin alone picks analog or digital mode.
// - port reads return zero for every pin configured as analog.
// - analog-select one means analog and read disabled; zero means digital, read enabled.
// - port A analog-select implements bits 10-9 and 7-6 only, reset to one.
// - small package lacks port A analog-select bits 10, 9 and 7.
// - port B analog-select implements all sixteen bits, read/write, reset to one.
module pioc_port_cfg
  import pioc_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // port A pins
  input  wire logic [15:0] pa_pin_in,
  output logic      [15:0] pa_pin_out,
  output logic      [15:0] pa_pin_oe_b,
  output logic      [15:0] pa_analog_select,
  // port B pins
  input  wire logic [15:0] pb_pin_in,
  output logic      [15:0] pb_pin_out,
  output logic      [15:0] pb_pin_oe_b,
  output logic      [15:0] pb_analog_select
);

  // implemented analog-select bits of port A; the smaller package keeps only bit 6,
  // so a write of ones to the missing positions reads back as zero there and
  // those pins stay digital for drive and read
  localparam pioc_word_t PA_MASK = SMALL_PKG ? `PIOC_PA_ANS_MASK_SM : `PIOC_PA_ANS_MASK;

  pioc_av_req_t   req;
  pioc_port_cfg_t pa_r, pa_nxt, pb_r, pb_nxt;
  pioc_bus_st_t   st_r, st_nxt;
  logic [31:0]    rdata_r, rdata_nxt;
  pioc_word_t     pa_sync1_r, pa_sync2_r, pb_sync1_r, pb_sync2_r;
  pioc_word_t     pa_sync1_nxt, pa_sync2_nxt, pb_sync1_nxt, pb_sync2_nxt;
  logic           wait_r, wait_nxt;
  pioc_word_t     pa_out_r, pa_out_nxt, pa_oe_r, pa_oe_nxt;
  pioc_word_t     pb_out_r, pb_out_nxt, pb_oe_r, pb_oe_nxt;
  pioc_word_t     wmask, wdata;
  pioc_word_t     pa_port_rd, pb_port_rd;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 byteenable: avs_byteenable, writedata: avs_writedata};

  // two-stage synchroniser; nothing but the second stage reads the first.
  // pins are taken as synchronous, but the two stages still set the read latency
  // that software covers with one idle instruction after a direction change
  always_comb begin
    pa_sync1_nxt = pa_pin_in;
    pa_sync2_nxt = pa_sync1_r;
    pb_sync1_nxt = pb_pin_in;
    pb_sync2_nxt = pb_sync1_r;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_sync1_r <= `PIOC_RST_ZERO;
      pa_sync2_r <= `PIOC_RST_ZERO;
      pb_sync1_r <= `PIOC_RST_ZERO;
      pb_sync2_r <= `PIOC_RST_ZERO;
    end else begin
      pa_sync1_r <= pa_sync1_nxt;
      pa_sync2_r <= pa_sync2_nxt;
      pb_sync1_r <= pb_sync1_nxt;
      pb_sync2_r <= pb_sync2_nxt;
    end
  end

  // analog pins gate the read path to zero
  assign pa_port_rd = pa_sync2_r & ~pa_r.ansel;
  assign pb_port_rd = pb_sync2_r & ~pb_r.ansel;

  // byte enables of the low half word; upper lanes hold nothing, so a write
  // with only lanes 2 and 3 enabled is taken and answered but changes nothing
  assign wmask = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  assign wdata = req.writedata[15:0];

  // bus slave: one wait cycle then the answer, so every access takes two edges.
  // a request is taken only in idle, so a master that holds read or write high
  // through the answer cycle is not served twice; the pin-read words are built
  // from the synchroniser output and the analog mask of the same edge
  always_comb begin
    pa_nxt    = pa_r;
    pb_nxt    = pb_r;
    st_nxt    = st_r;
    rdata_nxt = rdata_r;
    case (st_r)
      PIOC_IDLE: begin
        if (req.read || req.write) begin
          st_nxt    = PIOC_DONE;
          rdata_nxt = `PIOC_RD_ZERO;
          if (req.write) begin
            // byte-lane merge; the select words are clipped to the implemented bits
            case (req.address[5:2])
              `PIOC_OFS_PA_ANSEL: begin
                pa_nxt.ansel = ((pa_r.ansel & ~wmask) | (wdata & wmask)) & PA_MASK;
              end
              `PIOC_OFS_PA_DIR:   pa_nxt.dir = (pa_r.dir & ~wmask) | (wdata & wmask);
              `PIOC_OFS_PA_LAT:   pa_nxt.lat = (pa_r.lat & ~wmask) | (wdata & wmask);
              `PIOC_OFS_PA_ODC:   pa_nxt.odc = (pa_r.odc & ~wmask) | (wdata & wmask);
              `PIOC_OFS_PB_ANSEL: begin
                pb_nxt.ansel = ((pb_r.ansel & ~wmask) | (wdata & wmask)) & `PIOC_PB_ANS_MASK;
              end
              `PIOC_OFS_PB_DIR:   pb_nxt.dir = (pb_r.dir & ~wmask) | (wdata & wmask);
              `PIOC_OFS_PB_LAT:   pb_nxt.lat = (pb_r.lat & ~wmask) | (wdata & wmask);
              `PIOC_OFS_PB_ODC:   pb_nxt.odc = (pb_r.odc & ~wmask) | (wdata & wmask);
              default: ; // unmapped and pin-read words are dropped
            endcase
          end else begin
            // registers read back as stored; pin reads see analog pins as zero
            case (req.address[5:2])
              `PIOC_OFS_PA_ANSEL: rdata_nxt = {16'h0000, pa_r.ansel};
              `PIOC_OFS_PA_DIR:   rdata_nxt = {16'h0000, pa_r.dir};
              `PIOC_OFS_PA_LAT:   rdata_nxt = {16'h0000, pa_r.lat};
              `PIOC_OFS_PA_ODC:   rdata_nxt = {16'h0000, pa_r.odc};
              `PIOC_OFS_PA_PORT:  rdata_nxt = {16'h0000, pa_port_rd};
              `PIOC_OFS_PB_ANSEL: rdata_nxt = {16'h0000, pb_r.ansel};
              `PIOC_OFS_PB_DIR:   rdata_nxt = {16'h0000, pb_r.dir};
              `PIOC_OFS_PB_LAT:   rdata_nxt = {16'h0000, pb_r.lat};
              `PIOC_OFS_PB_ODC:   rdata_nxt = {16'h0000, pb_r.odc};
              `PIOC_OFS_PB_PORT:  rdata_nxt = {16'h0000, pb_port_rd};
              default:            rdata_nxt = `PIOC_RD_ZERO; // unmapped reads give zero
            endcase
          end
        end
      end
      PIOC_DONE: st_nxt = PIOC_IDLE;
      default:   st_nxt = PIOC_IDLE;
    endcase
    // waitrequest is registered so the bus sees a clean flop output; it drops
    // in the cycle after the request is taken and rises again one cycle later
    wait_nxt = (st_nxt == PIOC_IDLE);
  end

  // register file and bus state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // every implemented select bit comes up analog; the mask follows the package
      pa_r    <= '{ansel: `PIOC_RST_ANS & PA_MASK, dir: `PIOC_RST_DIR, lat: `PIOC_RST_ZERO,
                   odc: `PIOC_RST_ZERO};
      pb_r    <= '{ansel: `PIOC_RST_ANS, dir: `PIOC_RST_DIR, lat: `PIOC_RST_ZERO, odc: `PIOC_RST_ZERO};
      st_r    <= PIOC_IDLE;
      rdata_r <= `PIOC_RD_ZERO;
      wait_r  <= `PIOC_RST_WAIT;
    end else begin
      pa_r    <= pa_nxt;
      pb_r    <= pb_nxt;
      st_r    <= st_nxt;
      rdata_r <= rdata_nxt;
      wait_r  <= wait_nxt;
    end
  end

  // pin drivers: open drain only drops the high drive, the latch still steers low.
  // driven only when the direction bit says output and the select bit says digital;
  // with open drain and a latch one the pin is let go to the outside pull-up.
  // the drive lags a register write by one edge, which software covers anyway
  always_comb begin
    pa_out_nxt = pa_r.lat;
    pb_out_nxt = pb_r.lat;
    // an analog pin or an input never drives
    pa_oe_nxt  = ~(~pa_r.dir & ~(pa_r.ansel & PA_MASK) & ~(pa_r.odc & pa_r.lat));
    pb_oe_nxt  = ~(~pb_r.dir & ~pb_r.ansel & ~(pb_r.odc & pb_r.lat));
  end

  // pin drive registers; reset leaves every pin released
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_out_r <= `PIOC_RST_ZERO;
      pb_out_r <= `PIOC_RST_ZERO;
      pa_oe_r  <= `PIOC_RST_DIR;
      pb_oe_r  <= `PIOC_RST_DIR;
    end else begin
      pa_out_r <= pa_out_nxt;
      pb_out_r <= pb_out_nxt;
      pa_oe_r  <= pa_oe_nxt;
      pb_oe_r  <= pb_oe_nxt;
    end
  end

  // every output comes straight from a register
  assign pa_pin_out       = pa_out_r;
  assign pa_pin_oe_b      = pa_oe_r;
  assign pb_pin_out       = pb_out_r;
  assign pb_pin_oe_b      = pb_oe_r;
  assign pa_analog_select = pa_r.ansel;
  assign pb_analog_select = pb_r.ansel;
  assign avs_readdata     = rdata_r;
  assign avs_waitrequest  = wait_r; // high until the answer cycle
endmodule

// ---- verification/pioc_pin_model.sv ----
// pin model: device drive, open-drain release and external levels
`timescale 1ns/1ps
module pioc_pin_model (
  // device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_b,
  // level of outside world when released
  input  wire logic [15:0] ext_lvl,
  output logic      [15:0] pin_lvl
);
  // released bit shows the outside level, never the last driven value
  assign pin_lvl = (pin_out & ~pin_oe_b) | (ext_lvl & pin_oe_b);
endmodule

// ---- verification/pioc_port_cfg_monitor.sv ----
// checker for bus timing, analog select and pin drive
`timescale 1ns/1ps
module pioc_port_cfg_monitor #(
  // port A select reset word; the smaller package keeps only bit 6
  parameter logic [15:0] PA_RST = 16'h06c0
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic [15:0] pa_pin_oe_b,
  input wire logic [15:0] pa_analog_select,
  input wire logic [15:0] pb_pin_oe_b,
  input wire logic [15:0] pb_analog_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after request");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  chk_upper_zero: assert property (avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
  chk_pa_mask: assert property ((pa_analog_select & ~PA_RST) == 16'h0000)
    else $error("unimplemented select bit set");
  chk_rst_select: assert property (!$past(rst_b) |->
    pa_analog_select == PA_RST && pb_analog_select == 16'hffff) else $error("select reset value wrong");
  chk_pa_analog_oe: assert property ((~pa_pin_oe_b & $past(pa_analog_select)) == 16'h0000)
    else $error("analog pin driven");
  chk_pb_analog_oe: assert property ((~pb_pin_oe_b & $past(pb_analog_select)) == 16'h0000)
    else $error("analog pin driven");
  chk_read_zero: assert property (avs_read && avs_waitrequest && avs_address == 6'h30 |=>
    (avs_readdata[15:0] & $past(pb_analog_select)) == 16'h0000) else $error("analog pin read nonzero");
  chk_select_hold: assert property (!$stable(pb_analog_select) |-> $past(avs_write) && $past(avs_address) == 6'h20)
    else $error("select changed without write");
  cover property (avs_read && !avs_waitrequest && avs_address == 6'h30);
  cover property (avs_write && !avs_waitrequest && avs_address == 6'h20);
  cover property (pb_pin_oe_b != 16'hffff);
endmodule
bind pioc_port_cfg pioc_port_cfg_monitor #(.PA_RST(SMALL_PKG ? 16'h0040 : 16'h06c0)) i_mon (.sys_clk, .rst_b,
  .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .pa_pin_oe_b, .pa_analog_select, .pb_pin_oe_b, .pb_analog_select);

// ---- verification/pioc_port_cfg_tb_top.sv ----
// self-checking bench for the port configuration block
`timescale 1ns/1ps
module pioc_port_cfg_tb_top;
  logic        sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [5:0]  avs_address = 6'h00, p;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, e, exp_q[$], sm_readdata;
  logic [15:0] pa_pin_in, pa_pin_out, pa_pin_oe_b, pa_analog_select, ext_a = 16'h0, a, d, l, o, x, m;
  logic [15:0] pb_pin_in, pb_pin_out, pb_pin_oe_b, pb_analog_select, ext_b = 16'h0;
  int          num_errors = 0, num_checks = 0, cycles = 0, seed = 18831;
  always #5 sys_clk = ~sys_clk;
  pioc_port_cfg i_dut (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_byteenable(4'hf),
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pa_pin_in, .pa_pin_out, .pa_pin_oe_b, .pa_analog_select,
    .pb_pin_in, .pb_pin_out, .pb_pin_oe_b, .pb_analog_select);
  pioc_pin_model i_pa (.pin_out(pa_pin_out), .pin_oe_b(pa_pin_oe_b), .ext_lvl(ext_a), .pin_lvl(pa_pin_in));
  pioc_pin_model i_pb (.pin_out(pb_pin_out), .pin_oe_b(pb_pin_oe_b), .ext_lvl(ext_b), .pin_lvl(pb_pin_in));
  // small-package variant on the same bus; its port A select readback is compared
  pioc_port_cfg #(.SMALL_PKG(1'b1)) i_dut_sm (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_byteenable(4'hf), .avs_writedata, .avs_readdata(sm_readdata), .avs_waitrequest(), .pa_pin_in(ext_a),
    .pa_pin_out(), .pa_pin_oe_b(), .pa_analog_select(), .pb_pin_in(ext_b), .pb_pin_out(), .pb_pin_oe_b(),
    .pb_analog_select());
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one bus cycle; a read notes its expected word first
  task bus(input logic wr, input logic [5:0] adr, input logic [15:0] dat);
    @(posedge sys_clk);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, dat};
    if (!wr) exp_q.push_back({16'h0000, dat});
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // watcher: compares each read answer, and cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      end_of_test;
    end
    if (avs_read && avs_waitrequest === 1'b0) begin
      num_checks++;
      e = exp_q.pop_front();
      if (avs_readdata !== e) begin
        num_errors++;
        $display("mismatch at %0t: got %h expected %h", $time, avs_readdata, e);
      end
      if (avs_address == 6'h00) begin
        num_checks++;
        if (sm_readdata !== (e & 32'h0000_0040)) begin
          num_errors++;
          $display("mismatch at %0t: got %h expected %h", $time, sm_readdata, e & 32'h0000_0040);
        end
      end
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    ext_a <= 16'($random(seed));
    bus(1'b0, 6'h00, 16'h06c0);
    bus(1'b0, 6'h20, 16'hffff);
    bus(1'b0, 6'h30, 16'h0000);
    bus(1'b0, 6'h10, ext_a & ~16'h06c0);
    bus(1'b0, 6'h3c, 16'h0000);
    $display("reset values done");
    // random mode mix on both ports; released bits read the outside level
    for (int i = 0; i < 16; i++) begin
      p = i[0] ? 6'h20 : 6'h00;
      m = i[0] ? 16'hffff : 16'h06c0;
      {a, d} = $random(seed);
      {l, o} = $random(seed);
      x = 16'($random(seed));
      if (i[0]) ext_b <= x;
      else ext_a <= x;
      bus(1'b1, p, a);
      bus(1'b1, p + 6'h04, d);
      bus(1'b1, p + 6'h08, l);
      bus(1'b1, p + 6'h0c, o);
      bus(1'b0, p, a & m);
      bus(1'b0, p + 6'h04, d);
      bus(1'b0, p + 6'h08, l);
      bus(1'b0, p + 6'h0c, o);
      bus(1'b0, p + 6'h10, ~(a & m) & ((d & x) | (~d & l & (~o | x))));
    end
    $display("mode mix done");
    // second reset in mid-run: both select words and the port B direction and latch must fall back
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(1'b0, 6'h00, 16'h06c0);
    bus(1'b0, 6'h20, 16'hffff);
    bus(1'b0, 6'h24, 16'hffff);
    bus(1'b0, 6'h28, 16'h0000);
    $display("mid-run reset done");
    end_of_test;
  end
endmodule
